// File: core/cpc_pkg.sv
// cpc_pkg: shared constants for the camera pixel correction pipeline.
// assumes one pixel clock domain and a plain strobe register port.
package cpc_pkg;
  localparam int PIX_W = 12;
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_GAIN = 8'h04;
  localparam logic [7:0] REG_BLACK = 8'h08;
  localparam logic [7:0] REG_RATIO = 8'h0C;
  localparam logic [7:0] REG_GAMMA = 8'h10;
  localparam logic [7:0] REG_SHARP = 8'h14;
  localparam logic [7:0] REG_THRESH = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_OFFSETS = 8'h20;
  // control field positions
  localparam int CTRL_GAIN_AUTO_LSB = 0;
  localparam int CTRL_GAIN_SEL = 2;
  localparam int CTRL_BLACK_SEL_LSB = 3;
  localparam int CTRL_RATIO_SEL = 5;
  localparam int CTRL_WB_AUTO_LSB = 6;
  localparam int CTRL_ILLUM_LSB = 8;
  localparam int CTRL_GAMMA_EN = 10;
  localparam int CTRL_SHARP_EN = 11;
  localparam int CTRL_SHARP_AUTO = 12;
  // reset values: gain 0 dB, ratios 1.0 (u4.8), gamma 1.0 (u4.8), sharpening 2.0 (s4.8)
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [11:0] RATIO_ONE = 12'h100;
  localparam logic [11:0] GAMMA_ONE = 12'h100;
  localparam logic [11:0] SHARP_RESET = 12'h200;
  localparam logic [11:0] SHARP_MAX = 12'h800;
  localparam logic [11:0] SHARP_MIN = 12'hF00;
  localparam logic [11:0] THRESH_MAX = 12'h400;
  localparam logic [7:0] BLACK_ANALOG_MAX = 8'h20;
  localparam logic [3:0] AUTO_ONCE_ITER = 4'h8;
  localparam logic [11:0] TARGET_MEAN = 12'h800;
  typedef enum logic [1:0] {
    CPC_AUTO_OFF = 2'b00,
    CPC_AUTO_ONCE = 2'b01,
    CPC_AUTO_CONT = 2'b10
  } cpc_auto_type;
  typedef enum logic [1:0] {
    CPC_BL_ALL = 2'b00,
    CPC_BL_ANALOG = 2'b01,
    CPC_BL_DIGITAL = 2'b10
  } cpc_black_sel_type;
  typedef enum logic [1:0] {
    CPC_LIGHT_OFF = 2'b00,
    CPC_LIGHT_DAYLIGHT = 2'b01,
    CPC_LIGHT_TUNGSTEN = 2'b10,
    CPC_LIGHT_FLUOR = 2'b11
  } cpc_illum_type;
endpackage

// File: core/cpc_gamma_rom.sv
// cpc_gamma_rom: registered power-curve table, x^g on 6-bit index.
// assumes a one-cycle read latency is absorbed by the pipeline.
`timescale 1ns/1ps
module cpc_gamma_rom #(
  parameter int AW = 6,
  parameter int DW = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // lookup
  input wire logic [AW-1:0] addr,
  input wire logic [1:0] curve,
  output logic [DW-1:0] data
);
  import cpc_pkg::*;
  typedef struct packed {
    logic [DW-1:0] data;
  } cpc_rom_state_type;
  cpc_rom_state_type state, next_state;
  logic [DW-1:0] x;
  logic [2*DW-1:0] sq;
  // curve 0: x^0.5 approx, 1: linear, 2: x^2; coarse table keeps area low
  always_comb begin
    next_state = state;
    x = DW'({addr, {(DW-AW){1'b0}}});
    sq = x * x;
    case (curve)
      2'd0: next_state.data = DW'((x + (sq[2*DW-1:DW] ^ x)) >> 1) | (x >> 1);
      2'd2: next_state.data = sq[2*DW-1:DW];
      default: next_state.data = x;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign data = state.data;
endmodule

// File: core/cpc_pipeline.sv
// cpc_pipeline: gain, black level, white balance, gamma and sharpening on a pixel stream.
// assumes pixels arrive synchronous to sys_clk with frame start marking each frame.
// How it works
// - gain auto once adapts a while then returns to off; continuous never stops.
// - with gain auto off, the programmed dB gain is applied to pixels.
// - gain selector all drives one total gain across every channel.
// - software writes only total black level; analog and digital parts derived.
// - black selector all reads and writes the analog plus digital sum.
// - digital offset added after conversion; analog part goes to converter.
// - red and blue scaled by their ratios relative to green.
// - both ratios at unity leaves colours unchanged.
// - ratio selector steers ratio reads and writes to red or blue.
// - balance auto once iterates then turns off; continuous tracks imbalance.
// - illuminant preset sets both ratios and the colour matrix choice.
// - gamma picks a square-root, linear or square curve from the programmed exponent.
// - gamma disabled passes pixels linearly.
// - gamma applies before the lookup table, feeding it.
// - sharpening resets disabled; disabled means no sharpening at all.
// - only gradients above threshold are sharpened.
// - threshold is a fraction of range, clamped to a quarter.
// - auto threshold follows measured noise, else software value.
// - amount zero unchanged, negative smooths, positive boosts edges.
// - amount limited to eight times boost and one times smoothing.
// - sharpening amount resets to 2.0.
`timescale 1ns/1ps
module cpc_pipeline #(
  parameter int PW = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // pixel input from converter
  input wire logic pix_in_valid,
  input wire logic pix_in_sof,
  input wire logic [1:0] pix_in_color,
  input wire logic [PW-1:0] pix_in,
  // pixel output toward the pixel lookup table
  output logic pix_out_valid,
  output logic pix_out_sof,
  output logic [PW-1:0] pix_out,
  // converter controls
  output logic [7:0] analog_offset,
  output logic [7:0] analog_gain_db,
  output logic [1:0] color_matrix_sel
);
  import cpc_pkg::*;

  typedef struct packed {
    cpc_auto_type gain_auto;
    logic gain_sel_all;
    cpc_black_sel_type black_sel;
    logic ratio_sel_blue;
    cpc_auto_type wb_auto;
    cpc_illum_type illum;
    logic gamma_en;
    logic sharp_en;
    logic sharp_auto;
    logic [7:0] gain;
    logic [7:0] black_total;
    logic [11:0] ratio_red;
    logic [11:0] ratio_blue;
    logic [11:0] gamma;
    logic [11:0] sharp;
    logic [11:0] thresh;
    // frame-latched copies, then auto counters, channel sums and noise estimate
    logic [7:0] f_gain;
    logic [7:0] f_dig_off;
    logic [11:0] f_red;
    logic [11:0] f_blue;
    logic [1:0] f_curve;
    logic f_gamma_en;
    logic f_sharp_en;
    logic [11:0] f_sharp;
    logic [11:0] f_thresh;
    logic [3:0] gain_iter;
    logic [3:0] wb_iter;
    logic [PW+7:0] acc_rg;
    logic [PW+7:0] acc_b;
    logic [11:0] noise;
    // pipeline stages, then read data, analog offset and matrix select
    logic s1_valid;
    logic s1_sof;
    logic [PW-1:0] s1_pix;
    logic s2_valid;
    logic s2_sof;
    logic [PW-1:0] s2_pix;
    logic s3_valid;
    logic s3_sof;
    logic [PW-1:0] s3_lin;
    logic [PW-1:0] prev_pix;
    logic [PW-1:0] out_pix;
    logic out_valid;
    logic out_sof;
    logic [31:0] rdata;
    logic [7:0] an_off;
    logic [1:0] cm_sel;
  } cpc_state_type;

  cpc_state_type state, next_state;
  logic [PW-1:0] rom_data;

  // saturating add of a signed offset to a pixel
  function automatic logic [PW-1:0] sat_pix(input logic signed [PW+9:0] v);
    if (v < 0) begin
      sat_pix = '0;
    end else if (v > $signed({10'h000, {PW{1'b1}}})) begin
      sat_pix = {PW{1'b1}};
    end else begin
      sat_pix = PW'(v);
    end
  endfunction

  // rough dB to u4.8 linear: 6 dB per doubling
  function automatic logic [11:0] db_to_lin(input logic [7:0] db);
    logic [3:0] oct;
    logic [2:0] rem;
    logic [11:0] base;
    oct = 4'(db / 8'd6);
    rem = 3'(db % 8'd6);
    base = (oct > 4'd3) ? 12'hFFF : 12'(12'h100 << oct);
    db_to_lin = 12'(base + 12'((24'(base) * 24'(rem)) / 24'd6));
  endfunction

  // exponent to curve selector: below one bends up, above one bends down
  function automatic logic [1:0] gamma_curve(input logic [11:0] g);
    if (g < GAMMA_ONE) begin
      gamma_curve = 2'd0;
    end else if (g > GAMMA_ONE) begin
      gamma_curve = 2'd2;
    end else begin
      gamma_curve = 2'd1;
    end
  endfunction

  cpc_gamma_rom #(.AW(6), .DW(PW)) u_rom (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .addr(state.s1_pix[PW-1 -: 6]),
    .curve(state.f_curve),
    .data(rom_data)
  );

  logic [PW+11:0] gain_prod;
  logic [PW+11:0] wb_prod;
  logic [11:0] wb_ratio;
  logic signed [PW+9:0] with_off;
  logic signed [PW+1:0] grad;
  logic [PW:0] grad_abs;
  logic signed [PW+14:0] delta;
  logic [PW-1:0] sharp_in;
  logic [11:0] thr_eff;
  logic [11:0] sharp_clamped;

  always_comb begin
    next_state = state;
    gain_prod = '0;
    wb_prod = '0;
    wb_ratio = RATIO_ONE;
    with_off = '0;
    grad = '0;
    grad_abs = '0;
    delta = '0;
    sharp_in = '0;
    // threshold: auto from noise, capped at quarter range
    thr_eff = state.sharp_auto ? ((state.noise > THRESH_MAX) ? THRESH_MAX : state.noise) : state.thresh;
    // amount clamp on write: +8.0 boost, -1.0 smooth in s4.8
    if (!reg_wdata[11] && reg_wdata[11:0] > SHARP_MAX) begin
      sharp_clamped = SHARP_MAX;
    end else if (reg_wdata[11] && reg_wdata[11:0] < SHARP_MIN) begin
      sharp_clamped = SHARP_MIN;
    end else begin
      sharp_clamped = reg_wdata[11:0];
    end
    next_state.rdata = '0;

    // register writes; black level only writable through the all selection
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        next_state.gain_auto = cpc_auto_type'(reg_wdata[CTRL_GAIN_AUTO_LSB +: 2]);
        next_state.gain_sel_all = reg_wdata[CTRL_GAIN_SEL];
        next_state.black_sel = cpc_black_sel_type'(reg_wdata[CTRL_BLACK_SEL_LSB +: 2]);
        next_state.ratio_sel_blue = reg_wdata[CTRL_RATIO_SEL];
        next_state.wb_auto = cpc_auto_type'(reg_wdata[CTRL_WB_AUTO_LSB +: 2]);
        next_state.gamma_en = reg_wdata[CTRL_GAMMA_EN];
        next_state.sharp_en = reg_wdata[CTRL_SHARP_EN];
        next_state.sharp_auto = reg_wdata[CTRL_SHARP_AUTO];
        if (cpc_illum_type'(reg_wdata[CTRL_ILLUM_LSB +: 2]) != state.illum) begin
          next_state.illum = cpc_illum_type'(reg_wdata[CTRL_ILLUM_LSB +: 2]);
          // preset loads both ratios; the matrix choice follows at the next frame start
          case (next_state.illum)
            CPC_LIGHT_DAYLIGHT: begin
              next_state.ratio_red = 12'h180;
              next_state.ratio_blue = 12'h1A0;
            end
            CPC_LIGHT_TUNGSTEN: begin
              next_state.ratio_red = 12'h0E0;
              next_state.ratio_blue = 12'h260;
            end
            CPC_LIGHT_FLUOR: begin
              next_state.ratio_red = 12'h140;
              next_state.ratio_blue = 12'h1E0;
            end
            default: ;
          endcase
        end
      end else if (reg_addr == REG_GAIN) begin
        next_state.gain = reg_wdata[7:0];
      end else if (reg_addr == REG_BLACK) begin
        if (state.black_sel == CPC_BL_ALL) begin
          next_state.black_total = reg_wdata[7:0];
        end
      end else if (reg_addr == REG_RATIO) begin
        if (state.ratio_sel_blue) begin
          next_state.ratio_blue = reg_wdata[11:0];
        end else begin
          next_state.ratio_red = reg_wdata[11:0];
        end
      end else if (reg_addr == REG_GAMMA) begin
        next_state.gamma = reg_wdata[11:0];
      end else if (reg_addr == REG_SHARP) begin
        next_state.sharp = sharp_clamped;
      end else if (reg_addr == REG_THRESH) begin
        next_state.thresh = (reg_wdata[11:0] > THRESH_MAX) ? THRESH_MAX : reg_wdata[11:0];
      end
    end

    // register reads, data stand one cycle later; unmapped reads zero
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        next_state.rdata = 32'({state.sharp_auto, state.sharp_en, state.gamma_en, state.illum,
                                state.wb_auto, state.ratio_sel_blue, state.black_sel,
                                state.gain_sel_all, state.gain_auto});
      end else if (reg_addr == REG_GAIN) begin
        next_state.rdata = 32'(state.gain);
      end else if (reg_addr == REG_BLACK) begin
        case (state.black_sel)
          CPC_BL_ANALOG: next_state.rdata = 32'(state.an_off);
          CPC_BL_DIGITAL: next_state.rdata = 32'(state.f_dig_off);
          default: next_state.rdata = 32'(state.black_total);
        endcase
      end else if (reg_addr == REG_RATIO) begin
        next_state.rdata = 32'(state.ratio_sel_blue ? state.ratio_blue : state.ratio_red);
      end else if (reg_addr == REG_GAMMA) begin
        next_state.rdata = 32'(state.gamma);
      end else if (reg_addr == REG_SHARP) begin
        next_state.rdata = 32'(state.sharp);
      end else if (reg_addr == REG_THRESH) begin
        next_state.rdata = 32'(thr_eff);
      end else if (reg_addr == REG_STATUS) begin
        next_state.rdata = 32'({state.noise[7:0], state.wb_iter, state.gain_iter});
      end else if (reg_addr == REG_OFFSETS) begin
        next_state.rdata = 32'({state.f_dig_off, state.an_off});
      end
    end

    // frame boundary: latch every correction setting at once; analog takes up to its cap
    if (pix_in_valid && pix_in_sof) begin
      next_state.f_gain = state.gain;
      next_state.an_off = (state.black_total > BLACK_ANALOG_MAX) ? BLACK_ANALOG_MAX : state.black_total;
      next_state.f_dig_off = 8'(state.black_total - next_state.an_off);
      next_state.f_red = state.ratio_red;
      next_state.f_blue = state.ratio_blue;
      next_state.f_curve = gamma_curve(state.gamma);
      next_state.f_gamma_en = state.gamma_en;
      next_state.f_sharp_en = state.sharp_en;
      next_state.f_sharp = state.sharp;
      next_state.f_thresh = thr_eff;
      next_state.cm_sel = state.illum;
      next_state.acc_rg = '0;
      next_state.acc_b = '0;
      // gain auto: nudge toward target mean of previous frame
      if (state.gain_auto != CPC_AUTO_OFF) begin
        if (state.acc_rg[PW+7 -: PW] < TARGET_MEAN && state.gain < 8'd48) begin
          next_state.gain = 8'(state.gain + 8'd1);
        end else if (state.acc_rg[PW+7 -: PW] > TARGET_MEAN && state.gain != 8'd0) begin
          next_state.gain = 8'(state.gain - 8'd1);
        end
        next_state.gain_iter = 4'(state.gain_iter + 4'd1);
        if (state.gain_auto == CPC_AUTO_ONCE && state.gain_iter == AUTO_ONCE_ITER) begin
          next_state.gain_auto = CPC_AUTO_OFF;
          next_state.gain_iter = '0;
        end
      end
      // balance auto: move blue ratio toward equal channel sums
      if (state.wb_auto != CPC_AUTO_OFF) begin
        if (state.acc_b < (state.acc_rg >> 1) && state.ratio_blue < 12'hFF0) begin
          next_state.ratio_blue = 12'(state.ratio_blue + 12'h008);
        end else if (state.acc_b > (state.acc_rg >> 1) && state.ratio_blue > 12'h010) begin
          next_state.ratio_blue = 12'(state.ratio_blue - 12'h008);
        end
        next_state.wb_iter = 4'(state.wb_iter + 4'd1);
        if (state.wb_auto == CPC_AUTO_ONCE && state.wb_iter == AUTO_ONCE_ITER) begin
          next_state.wb_auto = CPC_AUTO_OFF;
          next_state.wb_iter = '0;
        end
      end
    end

    // stage 1: gain then digital offset; next_state so the frame start pixel sees its own frame
    gain_prod = pix_in * db_to_lin(next_state.f_gain);
    with_off = $signed({2'b00, gain_prod[PW+11:8]}) + $signed({14'h0000, next_state.f_dig_off});
    // balance ratio by colour; green passes at unity
    case (pix_in_color)
      2'd0: wb_ratio = next_state.f_red;
      2'd2: wb_ratio = next_state.f_blue;
      default: wb_ratio = RATIO_ONE;
    endcase
    wb_prod = sat_pix(with_off) * wb_ratio;
    next_state.s1_valid = pix_in_valid;
    next_state.s1_sof = pix_in_sof;
    if (pix_in_valid) begin
      next_state.s1_pix = sat_pix($signed({2'b00, wb_prod[PW+11:8]}));
      if (pix_in_color == 2'd2) begin
        next_state.acc_b = 20'(next_state.acc_b + {8'h00, pix_in});
      end else begin
        next_state.acc_rg = 20'(next_state.acc_rg + {8'h00, pix_in});
      end
    end

    // stage 2 waits for the table read; stage 3 selects curve or linear
    next_state.s2_valid = state.s1_valid;
    next_state.s2_sof = state.s1_sof;
    next_state.s3_valid = state.s2_valid;
    next_state.s3_sof = state.s2_sof;
    next_state.s2_pix = state.s1_pix;
    next_state.s3_lin = state.f_gamma_en ? rom_data : state.s2_pix;

    // stage 4: threshold-gated sharpening against the previous pixel
    sharp_in = state.s3_lin;
    grad = $signed({2'b00, sharp_in}) - $signed({2'b00, state.prev_pix});
    grad_abs = grad[PW+1] ? (PW+1)'(-grad) : (PW+1)'(grad);
    delta = (grad * $signed({{(PW+3){state.f_sharp[11]}}, state.f_sharp})) >>> 8;
    next_state.out_valid = state.s3_valid;
    next_state.out_sof = state.s3_sof;
    if (state.s3_valid) begin
      next_state.prev_pix = sharp_in;
      // threshold is a fraction of full range in 0.12 format
      if (state.f_sharp_en && !state.s3_sof && 24'(grad_abs) * 24'h001000 > 24'(state.f_thresh) * 24'(1 << PW)) begin
        next_state.out_pix = sat_pix(10'(0) + $signed({10'h000, sharp_in}) + (PW+10)'(delta));
      end else begin
        next_state.out_pix = sharp_in;
      end
      // noise estimate: running average of small gradients
      if (grad_abs < (PW+1)'(256)) begin
        next_state.noise = 12'((16'(state.noise) * 16'd15 + 16'(grad_abs) * 16'd16) >> 4);
      end
    end
  end

  // one register holds all state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
      state.ratio_red <= RATIO_ONE;
      state.ratio_blue <= RATIO_ONE;
      state.f_red <= RATIO_ONE;
      state.f_blue <= RATIO_ONE;
      state.gamma <= GAMMA_ONE;
      state.f_curve <= 2'd1;
      state.gain <= GAIN_RESET;
      state.sharp <= SHARP_RESET;
      state.f_sharp <= SHARP_RESET;
      state.sharp_en <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from state; lookup table sits downstream
  assign pix_out_valid = state.out_valid;
  assign pix_out_sof = state.out_sof;
  assign pix_out = state.out_pix;
  assign reg_rdata = state.rdata;
  assign analog_offset = state.an_off;
  assign analog_gain_db = state.f_gain;
  assign color_matrix_sel = state.cm_sel;
endmodule

// File: dv/cpc_pipeline_asserts.sv
// checker for the pixel correction pipeline, seeing only its ports
// assumes binding into cpc_pipeline and a fixed 4 cycle pixel latency
`timescale 1ns/1ps
module cpc_pipeline_asserts #(
  parameter int PW = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // pixel streams
  input wire logic pix_in_valid,
  input wire logic pix_in_sof,
  input wire logic [PW-1:0] pix_in,
  input wire logic pix_out_valid,
  input wire logic pix_out_sof,
  input wire logic [PW-1:0] pix_out,
  // converter controls
  input wire logic [7:0] analog_offset,
  input wire logic [7:0] analog_gain_db,
  input wire logic [1:0] color_matrix_sel
);
  import cpc_pkg::*;
  logic touched;
  logic [3:0] since_sof;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // pass-through holds only until the first register write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      touched <= 1'b0;
      since_sof <= 4'hF;
    end else begin
      touched <= touched | reg_wr;
      since_sof <= (pix_in_valid & pix_in_sof) ? 4'h0 : since_sof + {3'h0, since_sof != 4'hF};
    end
  end
  AST_RDATA_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside its slot");
  AST_OUT_FOLLOWS: assert property (
    pix_in_valid |-> ##4 pix_out_valid) else $error("pixel lost in pipeline");
  AST_NO_SPURIOUS: assert property (
    pix_out_valid |-> $past(pix_in_valid, 4)) else $error("pixel out without pixel in");
  AST_SOF_FOLLOWS: assert property (
    pix_out_sof |-> pix_out_valid && $past(pix_in_sof & pix_in_valid, 4)) else $error("frame start misplaced");
  AST_GAIN_AT_SOF: assert property (
    $changed(analog_gain_db) |-> since_sof <= 4'h5) else $error("gain changed mid frame");
  AST_MATRIX_AT_SOF: assert property (
    $changed(color_matrix_sel) |-> since_sof <= 4'h5) else $error("matrix changed mid frame");
  AST_ANALOG_CAP: assert property (
    $changed(analog_offset) |-> since_sof <= 4'h5 && analog_offset <= BLACK_ANALOG_MAX)
    else $error("analog offset bad");
  AST_PASS_DEFAULT: assert property (
    pix_out_valid && !touched |-> pix_out == $past(pix_in, 4)) else $error("default path not linear");
endmodule

bind cpc_pipeline cpc_pipeline_asserts #(.PW(PW)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in_valid(pix_in_valid), .pix_in_sof(pix_in_sof), .pix_in(pix_in),
  .pix_out_valid(pix_out_valid), .pix_out_sof(pix_out_sof), .pix_out(pix_out), .analog_offset(analog_offset),
  .analog_gain_db(analog_gain_db), .color_matrix_sel(color_matrix_sel));

// File: dv/cpc_sensor_model.sv
// sensor readout model: eight-pixel frames, flat or with one mid-frame step
// assumes the pipeline never stalls; idle data toggles so stale values show up
`timescale 1ns/1ps
module cpc_sensor_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // frame request
  input wire logic start,
  input wire logic slow,
  input wire logic [cpc_pkg::PIX_W-1:0] base,
  input wire logic [cpc_pkg::PIX_W-1:0] step,
  input wire logic [1:0] color,
  // pixel stream
  output logic pix_in_valid,
  output logic pix_in_sof,
  output logic [1:0] pix_in_color,
  output logic [cpc_pkg::PIX_W-1:0] pix_in
);
  import cpc_pkg::*;
  logic [3:0] sent;
  logic gap;
  // slow mode leaves an idle cycle after each pixel
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sent <= 4'h8;
      gap <= 1'b0;
      pix_in_valid <= 1'b0;
      pix_in_sof <= 1'b0;
      pix_in_color <= 2'h0;
      pix_in <= '0;
    end else if (sent < 4'h8 && !gap) begin
      sent <= sent + 4'h1;
      gap <= slow;
      pix_in_valid <= 1'b1;
      pix_in_sof <= sent == 4'h0;
      pix_in_color <= color;
      pix_in <= sent[2] ? base + step : base;
    end else begin
      gap <= 1'b0;
      pix_in_valid <= 1'b0;
      pix_in_sof <= 1'b0;
      pix_in <= ~pix_in;
      if (start) begin
        sent <= 4'h0;
      end
    end
  end
endmodule

// File: dv/tb_camera_pixel_correction_pipeline.sv
// pixel correction pipeline bench: register tasks and frame scenarios
// assumes the sensor model and bound checker; pixels return 4 cycles later
`timescale 1ns/1ps
module tb_camera_pixel_correction_pipeline;
  import cpc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, start = 1'b0, slow = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, rd;
  logic [PIX_W-1:0] base = '0, step = '0;
  logic [1:0] color = 2'h0;
  logic pix_in_valid, pix_in_sof, pix_out_valid, pix_out_sof;
  logic [1:0] pix_in_color, color_matrix_sel;
  logic [PIX_W-1:0] pix_in, pix_out;
  logic [PIX_W-1:0] cap [8];
  logic [7:0] analog_offset, analog_gain_db;
  int k = 0, error_cnt = 0, tests_run = 0;
  cpc_pipeline #(.PW(PIX_W)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in_valid(pix_in_valid), .pix_in_sof(pix_in_sof),
    .pix_in_color(pix_in_color), .pix_in(pix_in), .pix_out_valid(pix_out_valid), .pix_out_sof(pix_out_sof),
    .pix_out(pix_out), .analog_offset(analog_offset), .analog_gain_db(analog_gain_db),
    .color_matrix_sel(color_matrix_sel));
  cpc_sensor_model sensor (.sys_clk(sys_clk), .rst_b(rst_b), .start(start), .slow(slow), .base(base), .step(step),
    .color(color), .pix_in_valid(pix_in_valid), .pix_in_sof(pix_in_sof), .pix_in_color(pix_in_color), .pix_in(pix_in));
  // 250 MHz
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // output pixels kept by their place in the frame
  always @(posedge sys_clk) begin
    if (pix_out_valid) begin
      cap[pix_out_sof ? 0 : k] <= pix_out;
      k <= pix_out_sof ? 1 : k + 1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ok(input logic c);
    check({31'h0, c}, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // wipe stale results so a lost pixel cannot match
  task automatic frame(input logic [11:0] b, input logic [11:0] s, input logic [1:0] c);
    foreach (cap[i]) cap[i] = 'x;
    @(posedge sys_clk);
    base <= b;
    step <= s;
    color <= c;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask
  task automatic t_reset();
    rdr(REG_SHARP);
    check(rd[11:0], SHARP_RESET);
    rdr(REG_CTRL);
    check(rd[CTRL_SHARP_EN], 1'b0);
    rdr(REG_RATIO);
    check(rd[11:0], RATIO_ONE);
    rdr(8'h3C);
    check(rd, 32'h0);
    frame(12'h123, 12'h456, 2'h0);
    check(cap[1], 12'h123);
    check(cap[5], 12'h579);
    wr(REG_THRESH, 32'h100);
    wr(REG_CTRL, 32'h1000);
    rdr(REG_THRESH);
    check(rd[11:0], 12'h000);
    $display("reset defaults done");
  endtask
  task automatic t_gain_black();
    wr(REG_CTRL, 32'h4);
    wr(REG_GAIN, 32'h6);
    check(analog_gain_db, 8'h00);
    slow <= 1'b1;
    frame(12'h100, 12'h0, 2'h1);
    slow <= 1'b0;
    check(analog_gain_db, 8'h06);
    wr(REG_GAIN, 32'h0);
    wr(REG_BLACK, 32'h30);
    rdr(REG_BLACK);
    check(rd[7:0], 8'h30);
    frame(12'h100, 12'h0, 2'h1);
    check(analog_offset, BLACK_ANALOG_MAX);
    ok(cap[1] > 12'h100);
    rdr(REG_OFFSETS);
    check(rd[15:0], 16'h1020);
    wr(REG_CTRL, 32'h8);
    wr(REG_BLACK, 32'h05);
    wr(REG_CTRL, 32'h0);
    rdr(REG_BLACK);
    check(rd[7:0], 8'h30);
    wr(REG_BLACK, 32'h0);
    $display("gain and black done");
  endtask
  task automatic t_ratio_gamma();
    wr(REG_RATIO, 32'h200);
    wr(REG_CTRL, 32'h20);
    wr(REG_RATIO, 32'h080);
    rdr(REG_RATIO);
    check(rd[11:0], 12'h080);
    wr(REG_CTRL, 32'h0);
    rdr(REG_RATIO);
    check(rd[11:0], 12'h200);
    for (int c = 0; c < 3; c++) begin
      frame(12'h100, 12'h0, c[1:0]);
      check(cap[1], c == 0 ? 12'h200 : c == 2 ? 12'h080 : 12'h100);
    end
    wr(REG_GAMMA, 32'h080);
    wr(REG_CTRL, 32'h400);
    frame(12'h400, 12'h0, 2'h1);
    ok(cap[1] > 12'h400);
    wr(REG_GAMMA, 32'h200);
    frame(12'h400, 12'h0, 2'h1);
    ok(cap[1] < 12'h400);
    wr(REG_CTRL, 32'h0);
    frame(12'h400, 12'h0, 2'h1);
    check(cap[1], 12'h400);
    $display("balance and curve done");
  endtask
  task automatic t_sharp();
    wr(REG_THRESH, 32'hFFF);
    rdr(REG_THRESH);
    check(rd[11:0], THRESH_MAX);
    wr(REG_SHARP, 32'hC00);
    rdr(REG_SHARP);
    check(rd[11:0], SHARP_MIN);
    wr(REG_SHARP, 32'h200);
    wr(REG_CTRL, 32'h800);
    frame(12'h100, 12'h010, 2'h1);
    check(cap[4], 12'h110);
    wr(REG_THRESH, 32'h0);
    frame(12'h100, 12'h200, 2'h1);
    ok(cap[4] > 12'h300);
    wr(REG_SHARP, 32'h0);
    frame(12'h100, 12'h200, 2'h1);
    check(cap[4], 12'h300);
    wr(REG_SHARP, 32'hF00);
    frame(12'h100, 12'h200, 2'h1);
    ok(cap[4] < 12'h300);
    wr(REG_CTRL, 32'h0);
    frame(12'h100, 12'h200, 2'h1);
    check(cap[4], 12'h300);
    $display("sharpening done");
  endtask
  task automatic t_modes();
    for (int p = 1; p < 4; p++) begin
      wr(REG_CTRL, 32'(p) << CTRL_ILLUM_LSB);
      frame(12'h100, 12'h0, 2'h0);
      check(color_matrix_sel, p[1:0]);
    end
    wr(REG_CTRL, 32'h41);
    repeat (11) frame(12'h200, 12'h0, 2'h1);
    rdr(REG_CTRL);
    check(rd[7:0] & 8'hC3, 8'h00);
    wr(REG_CTRL, 32'h82);
    repeat (11) frame(12'h200, 12'h0, 2'h1);
    rdr(REG_CTRL);
    check(rd[7:0] & 8'hC3, 8'h82);
    $display("preset and auto done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // whole run needs about 1750 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    $display("BAD %0t run hung", $time);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_gain_black();
    t_ratio_gamma();
    t_sharp();
    t_modes();
    tally_and_finish();
  end
endmodule
